// file: hw/sleep_wake_control.sv
// Sleep entry and wake control with the second peripheral flag register
// Assumes a core pulse per executed power-down instruction and AXI4-Lite
// Operation
// - Hardware sets each flag on its event, whatever the enables.
// - Flag register two: osc fail 7, comp2 6, comp1 5, nvm 4, collision 3.
// - Bits 2..0 of flag and enable register two read zero.
// - Power-down is entered only by the power-down instruction.
// - Entry clears the watchdog; it counts on if enabled in sleep.
// - Entry clears the power-down flag and sets the time-out flag.
// - CPU clock is gated off while asleep.
// - Low-frequency oscillator and timer oscillator keep running asleep.
// - Converter RC clock and sensing oscillator keep running asleep.
// - I/O ports hold their drive state while asleep.
// - Non-watchdog resets act alike asleep and awake.
// - Pin, brown-out, power-on reset fully reset; others wake and continue.
// - Next instruction is prefetched while power-down executes.
// - Interrupt wake needs the source enable; ignores the global enable.
// - Global enable clear: continue in line; set: vector to 0004h.
// - Watchdog is cleared on every wake.
// - Enabled flag already pending: instruction is a no-operation.
// - Flag pending during instruction: complete, then wake at once.
// - Crystal modes wait 1024 oscillator periods before resuming.
// - Peripheral flags interrupt only with the peripheral enable set.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sleep_wake_defines.svh"

module sleep_wake_control (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic sleep_exec,
  input wire logic clrwdt_exec,
  input wire logic [7:0] other_irq_pending,
  // Peripheral event pulses from other domains
  input wire sleep_wake_pkg::flag_event_s flag_event_async,
  input wire logic watchdog_timeout_async,
  // Core control
  output sleep_wake_pkg::core_ctrl_s core_ctrl,
  output logic prefetch_next,
  output logic irq_request,
  output logic asleep
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  sleep_wake_pkg::power_state_e state_r;
  logic [4:0] ev_meta_r, ev_sync_r, ev_prev_r;
  logic [1:0] dog_sync_r;
  logic dog_prev_r;
  logic [7:0] flags_two_r, enable_two_r, enable_one_r, irq_ctrl_r, dog_ctl_r;
  logic [7:0] status_r, sleep_ctrl_r;
  logic [10:0] ost_cnt_r;
  logic [7:0] aw_addr_r, ar_addr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_have_r, w_have_r;
  logic [4:0] ev_rise;
  logic dog_rise, wake_req, wr_fire, enter_sleep, sleep_nop, wake_now;

  // Byte write helper with implemented-bit mask
  function automatic logic [7:0] wr_byte(input logic [7:0] old_v, input logic [31:0] d,
                                         input logic [3:0] s, input logic [7:0] m);
    wr_byte = s[0] ? ((d[7:0] & m) | (old_v & ~m)) : old_v;
  endfunction

  // --------------------------------------------------------------------
  // Event synchronisers
  // --------------------------------------------------------------------
  // Two flops per async event, then edge detect on the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ev_meta_r <= 5'h00;
      ev_sync_r <= 5'h00;
      ev_prev_r <= 5'h00;
    end else begin
      ev_meta_r <= flag_event_async;
      ev_sync_r <= ev_meta_r;
      ev_prev_r <= ev_sync_r;
    end
  end

  // Watchdog time-out synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dog_sync_r <= 2'h0;
      dog_prev_r <= 1'b0;
    end else begin
      dog_sync_r <= {dog_sync_r[0], watchdog_timeout_async};
      dog_prev_r <= dog_sync_r[1];
    end
  end

  assign ev_rise = ev_sync_r & ~ev_prev_r;
  assign dog_rise = dog_sync_r[1] & ~dog_prev_r;

  // --------------------------------------------------------------------
  // Wake decision
  // --------------------------------------------------------------------
  // Register-two flag AND enable, OR any other pending source; the peripheral enable bit does not gate wake
  assign wake_req = (|(flags_two_r & enable_two_r & `MASK_FLAGS_TWO))
    | (|other_irq_pending);
  assign enter_sleep = sleep_exec && (state_r == sleep_wake_pkg::st_awake)
    && !wake_req;
  assign sleep_nop = sleep_exec && (state_r == sleep_wake_pkg::st_awake) && wake_req;
  assign wake_now = (state_r == sleep_wake_pkg::st_asleep) && (wake_req || dog_rise);
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

  // --------------------------------------------------------------------
  // Power state machine
  // --------------------------------------------------------------------
  // Sleep entry, crystal start-up wait and resume; outer reset is full reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= sleep_wake_pkg::st_awake;
      ost_cnt_r <= 11'd0;
    end else begin
      case (state_r)
        sleep_wake_pkg::st_awake: begin
          if (enter_sleep) begin
            state_r <= sleep_wake_pkg::st_asleep;
          end
        end
        sleep_wake_pkg::st_asleep: begin
          if (wake_now && sleep_ctrl_r[`BIT_CRYSTAL_MODE]) begin
            state_r <= sleep_wake_pkg::st_startup;
            ost_cnt_r <= `OST_CYCLES - 11'd1;
          end else if (wake_now) begin
            state_r <= sleep_wake_pkg::st_resume;
          end
        end
        sleep_wake_pkg::st_startup: begin
          if (ost_cnt_r == 11'd0) begin
            state_r <= sleep_wake_pkg::st_resume;
          end else begin
            ost_cnt_r <= ost_cnt_r - 11'd1;
          end
        end
        sleep_wake_pkg::st_resume: begin
          state_r <= sleep_wake_pkg::st_awake;
        end
        default: begin
          state_r <= sleep_wake_pkg::st_awake;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Core control outputs
  // --------------------------------------------------------------------
  // Only the CPU clock is gated; slow, timer and converter clocks run on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_ctrl <= '{watchdog_clear: 1'b1, cpu_clock_enable: 1'b1, hold_io: 1'b0,
                     vector_to_isr: 1'b0, continue_inline: 1'b0};
      prefetch_next <= 1'b0;
      asleep <= 1'b0;
      irq_request <= 1'b0;
    end else begin
      core_ctrl.watchdog_clear <= enter_sleep || clrwdt_exec || wake_now
        || (state_r == sleep_wake_pkg::st_startup);
      core_ctrl.cpu_clock_enable <= !(enter_sleep || state_r == sleep_wake_pkg::st_asleep
        || (state_r == sleep_wake_pkg::st_startup && !(ost_cnt_r == 11'd0)));
      core_ctrl.hold_io <= enter_sleep || (state_r == sleep_wake_pkg::st_asleep)
        || (state_r == sleep_wake_pkg::st_startup && !(ost_cnt_r == 11'd0));
      core_ctrl.vector_to_isr <= (state_r == sleep_wake_pkg::st_resume)
        && irq_ctrl_r[`BIT_GLOBAL_IRQ_ENABLE];
      core_ctrl.continue_inline <= (state_r == sleep_wake_pkg::st_resume)
        && !irq_ctrl_r[`BIT_GLOBAL_IRQ_ENABLE];
      prefetch_next <= sleep_exec;
      asleep <= enter_sleep || (state_r == sleep_wake_pkg::st_asleep);
      irq_request <= irq_ctrl_r[`BIT_GLOBAL_IRQ_ENABLE] && (
        (irq_ctrl_r[`BIT_PERIPHERAL_IRQ_ENABLE]
         && |(flags_two_r & enable_two_r & `MASK_FLAGS_TWO))
        || |other_irq_pending);
    end
  end

  // --------------------------------------------------------------------
  // Flag register two
  // --------------------------------------------------------------------
  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_two_r <= `RST_FLAGS_TWO;
    end else begin
      flags_two_r <= (((wr_fire && aw_addr_r == `OFS_PERIPHERAL_FLAGS_TWO)
        ? wr_byte(flags_two_r, wdata_r, wstrb_r, `MASK_FLAGS_TWO) : flags_two_r)
        | {ev_rise, 3'b000}) & `MASK_FLAGS_TWO;
    end
  end

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  // Power-down and time-out bits; untouched when sleep acts as a no-op
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= `RST_STATUS;
    end else if (enter_sleep) begin
      status_r[`BIT_POWER_DOWN_FLAG] <= 1'b0;
      status_r[`BIT_TIMEOUT_FLAG] <= 1'b1;
    end else if (dog_rise && state_r == sleep_wake_pkg::st_asleep) begin
      status_r[`BIT_TIMEOUT_FLAG] <= 1'b0;
    end else if (clrwdt_exec && !sleep_nop) begin
      status_r[`BIT_POWER_DOWN_FLAG] <= 1'b1;
      status_r[`BIT_TIMEOUT_FLAG] <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  // Enables, watchdog control and sleep control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_ctrl_r <= `RST_ENABLE;
      enable_one_r <= `RST_ENABLE;
      enable_two_r <= `RST_ENABLE;
      dog_ctl_r <= `RST_WATCHDOG;
      sleep_ctrl_r <= 8'h00;
    end else if (wr_fire) begin
      case (aw_addr_r)
        `OFS_INTERRUPT_CONTROL: irq_ctrl_r <= wr_byte(irq_ctrl_r, wdata_r, wstrb_r, 8'hff);
        `OFS_PERIPHERAL_ENABLE_ONE: begin
          enable_one_r <= wr_byte(enable_one_r, wdata_r, wstrb_r, 8'hff);
        end
        `OFS_PERIPHERAL_ENABLE_TWO: begin
          enable_two_r <= wr_byte(enable_two_r, wdata_r, wstrb_r, `MASK_FLAGS_TWO);
        end
        `OFS_WATCHDOG_CONTROL: dog_ctl_r <= wr_byte(dog_ctl_r, wdata_r, wstrb_r, `MASK_WATCHDOG);
        `OFS_SLEEP_CONTROL: sleep_ctrl_r <= wr_byte(sleep_ctrl_r, wdata_r, wstrb_r, 8'h01);
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------
  // Address and data taken in either order, response after both
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r[1:0] == 2'h0 && aw_addr_r <= `OFS_SLEEP_CONTROL)
          ? 2'h0 : 2'h3;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------
  // One-cycle ready, data one cycle later, unmapped reads DECERR
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ar_addr_r <= 8'h00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr_r <= s_axi_araddr;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `OFS_INTERRUPT_CONTROL: s_axi_rdata <= {24'h000000, irq_ctrl_r};
          `OFS_PERIPHERAL_ENABLE_ONE: s_axi_rdata <= {24'h000000, enable_one_r};
          `OFS_PERIPHERAL_ENABLE_TWO: s_axi_rdata <= {24'h000000, enable_two_r};
          `OFS_PERIPHERAL_FLAGS_ONE: s_axi_rdata <= {24'h000000, other_irq_pending};
          `OFS_PERIPHERAL_FLAGS_TWO: s_axi_rdata <= {24'h000000, flags_two_r};
          `OFS_CORE_STATUS: s_axi_rdata <= {24'h000000, status_r};
          `OFS_WATCHDOG_CONTROL: s_axi_rdata <= {24'h000000, dog_ctl_r};
          `OFS_SLEEP_CONTROL: s_axi_rdata <= {24'h000000, sleep_ctrl_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sleep_wake_control

// file: hw/sleep_wake_defines.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design file
`ifndef SLEEP_WAKE_DEFINES_SVH
`define SLEEP_WAKE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_INTERRUPT_CONTROL 8'h00
`define OFS_PERIPHERAL_ENABLE_ONE 8'h04
`define OFS_PERIPHERAL_ENABLE_TWO 8'h08
`define OFS_PERIPHERAL_FLAGS_ONE 8'h0c
`define OFS_PERIPHERAL_FLAGS_TWO 8'h10
`define OFS_CORE_STATUS 8'h14
`define OFS_WATCHDOG_CONTROL 8'h18
`define OFS_SLEEP_CONTROL 8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_TIMEOUT_FLAG 4
`define BIT_POWER_DOWN_FLAG 3
`define BIT_SOFT_WATCHDOG_EN 0
`define BIT_OSC_FAIL 7
`define BIT_COMPARATOR_TWO 6
`define BIT_COMPARATOR_ONE 5
`define BIT_NVM_WRITE_DONE 4
`define BIT_BUS_COLLISION 3
`define BIT_CRYSTAL_MODE 0
`define MASK_FLAGS_TWO 8'hf8
`define MASK_IRQ_CONTROL_EN 8'hf8
`define MASK_WATCHDOG 8'h3f

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_FLAGS_TWO 8'h00
`define RST_ENABLE 8'h00
`define RST_STATUS 8'h18
`define RST_WATCHDOG 8'h16
`define ISR_VECTOR 16'h0004

// ----------------------------------------------------------------------
// Timing: start-up delay in oscillator periods, one period per clock
// ----------------------------------------------------------------------
`define OST_PERIODS 1024
`define OST_CYCLES 11'd1024

`endif

// file: hw/sleep_wake_pkg.sv
// Types shared by the sleep and wake controller
// Assumes the defines header sits beside it
package sleep_wake_pkg;
  typedef enum logic [1:0] {
    st_awake,
    st_asleep,
    st_startup,
    st_resume
  } power_state_e;

  typedef struct packed {
    logic osc_fail;
    logic comparator_two;
    logic comparator_one;
    logic nvm_write_done;
    logic bus_collision;
  } flag_event_s;

  typedef struct packed {
    logic watchdog_clear;
    logic cpu_clock_enable;
    logic hold_io;
    logic vector_to_isr;
    logic continue_inline;
  } core_ctrl_s;
endpackage

// file: tb/sleep_wake_monitor.sv
// Concurrent checks on the sleep and wake controller ports
// Assumes a bind onto sleep_wake_control, one clock, active-high reset
`timescale 1ns/1ps

module sleep_wake_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Core side
  input wire logic sleep_exec,
  input wire logic [7:0] other_irq_pending,
  // Core control
  input wire sleep_wake_pkg::core_ctrl_s core_ctrl,
  input wire logic prefetch_next,
  input wire logic asleep
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Entry and exit of power-down
  // ----------------------------------------------------------------------
  sequence s_enter;
    !asleep ##1 asleep;
  endsequence

  sequence s_leave;
    asleep ##1 !asleep;
  endsequence

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_entry_by_instr: assert property (s_enter |-> $past(sleep_exec))
    else $error("power-down entered without the instruction");
  a_entry_prefetch: assert property (s_enter |-> prefetch_next)
    else $error("no prefetch when power-down instruction ran");
  a_entry_watchdog_clear: assert property (s_enter |-> core_ctrl.watchdog_clear)
    else $error("watchdog not cleared on entry");
  a_asleep_gated: assert property (asleep |-> !core_ctrl.cpu_clock_enable && core_ctrl.hold_io)
    else $error("clock running or ports released while asleep");
  a_wake_watchdog_clear: assert property (s_leave |-> core_ctrl.watchdog_clear
    || $past(core_ctrl.watchdog_clear))
    else $error("watchdog not cleared on wake");
  a_pending_nop: assert property (!asleep && sleep_exec && (other_irq_pending != 8'h00)
    |=> !asleep)
    else $error("slept although a wake source was pending");
  a_wake_on_other: assert property (asleep && (other_irq_pending != 8'h00)
    |-> ##[1:3] !asleep)
    else $error("enabled pending source did not wake");
  // Cycles from the fall of asleep until the resume pulse; covers crystal start-up
  logic [10:0] wake_wait_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wake_wait_r <= 11'h000;
    end else if (core_ctrl.continue_inline || core_ctrl.vector_to_isr) begin
      wake_wait_r <= 11'h000;
    end else if ($fell(asleep) || (wake_wait_r != 11'h000)) begin
      wake_wait_r <= wake_wait_r + 11'h001;
    end
  end
  a_resume_bound: assert property (wake_wait_r <= 11'd1040)
    else $error("no resume after wake");
  a_one_outcome: assert property (!(core_ctrl.continue_inline && core_ctrl.vector_to_isr))
    else $error("both in-line and vector resume");
endmodule // sleep_wake_monitor

bind sleep_wake_control sleep_wake_monitor mon (.clock(clock), .rst(rst),
  .sleep_exec(sleep_exec), .other_irq_pending(other_irq_pending), .core_ctrl(core_ctrl),
  .prefetch_next(prefetch_next), .asleep(asleep));

// file: tb/testbench.sv
// Self-checking bench for the sleep and wake controller
// Assumes the design package and defines header are compiled first
`timescale 1ns/1ps

module testbench;
  // ----------------------------------------------------------------------
  // Ports and bench state
  // ----------------------------------------------------------------------
  logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic sleep_exec, clrwdt_exec, watchdog_timeout_async, prefetch_next, irq_request, asleep;
  logic [7:0] s_axi_awaddr, s_axi_araddr, other_irq_pending;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  sleep_wake_pkg::flag_event_s flag_event_async;
  sleep_wake_pkg::core_ctrl_s core_ctrl;
  int errors, n_compared, n;
  logic vec;
  typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_s;
  // Address, write flag, write data, expected read, expected response
  row_s rows[10] = '{'{8'h10, 1'b0, 32'h0, 32'h00, 2'h0}, '{8'h08, 1'b0, 32'h0, 32'h00, 2'h0},
    '{8'h14, 1'b0, 32'h0, 32'h18, 2'h0}, '{8'h18, 1'b0, 32'h0, 32'h16, 2'h0},
    '{8'h00, 1'b0, 32'h0, 32'h00, 2'h0}, '{8'h08, 1'b1, 32'hff, 32'hf8, 2'h0},
    '{8'h18, 1'b1, 32'hff, 32'h3f, 2'h0}, '{8'h08, 1'b1, 32'h0, 32'h00, 2'h0},
    '{8'h20, 1'b0, 32'h0, 32'h00, 2'h3}, '{8'h18, 1'b1, 32'h16, 32'h16, 2'h0}};

  sleep_wake_control DUT (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
    .other_irq_pending(other_irq_pending), .flag_event_async(flag_event_async),
    .watchdog_timeout_async(watchdog_timeout_async), .core_ctrl(core_ctrl),
    .prefetch_next(prefetch_next), .irq_request(irq_request), .asleep(asleep));

  // ----------------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------------
  initial clock = 1'b0;
  always #5 clock = ~clock;

  // Cuts a hang short after far longer than the tests need
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Write one word; address and data released each at its own handshake
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 100) errors++;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      k++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 100) errors++;
  endtask

  // Event level held for one cycle, then dropped
  task automatic ev(input logic [4:0] v);
    @(posedge clock);
    flag_event_async <= v;
    @(posedge clock);
    flag_event_async <= 5'h00;
  endtask

  task automatic sleep_pulse();
    @(posedge clock);
    sleep_exec <= 1'b1;
    @(posedge clock);
    sleep_exec <= 1'b0;
    @(posedge clock);
  endtask

  // Counts cycles until the core is told how to resume
  task automatic wait_resume(output int c, output logic v);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (!(core_ctrl.continue_inline || core_ctrl.vector_to_isr) && c < 2000);
    v = core_ctrl.vector_to_isr;
    if (c >= 2000) errors++;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {sleep_exec, clrwdt_exec, watchdog_timeout_async} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, other_irq_pending, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    flag_event_async = 5'h00;
    errors = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // Register table: reset values, masks and an unmapped address
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_write(rows[i].a, rows[i].d, rsp);
        check("write response", {30'h0, rsp}, 32'h0);
      end
      axi_read(rows[i].a, rd, rsp);
      check("register read", rd, rows[i].e);
      check("read response", {30'h0, rsp}, {30'h0, rows[i].r});
    end
    $display("register table done");
    // Each event sets its own flag with all enables off
    for (int k = 0; k < 5; k++) begin
      ev(5'h01 << k);
      repeat (4) @(posedge clock);
      axi_read(8'h10, rd, rsp);
      check("flag position", rd, 32'h08 << k);
      axi_write(8'h10, 32'h0, rsp);
    end
    $display("flag order done");
    // Pending enabled flag turns the instruction into a no-operation
    axi_write(8'h08, 32'h08, rsp);
    ev(5'h01);
    repeat (4) @(posedge clock);
    sleep_pulse();
    check("asleep after nop", {31'h0, asleep}, 32'h0);
    axi_read(8'h14, rd, rsp);
    check("status after nop", rd, 32'h18);
    axi_write(8'h10, 32'h0, rsp);
    other_irq_pending <= 8'h01;
    sleep_pulse();
    other_irq_pending <= 8'h00;
    check("asleep other nop", {31'h0, asleep}, 32'h0);
    $display("pending no-op done");
    // Sleep, then wake in line on an enabled flag
    sleep_pulse();
    check("asleep", {31'h0, asleep}, 32'h1);
    check("cpu clock", {31'h0, core_ctrl.cpu_clock_enable}, 32'h0);
    axi_read(8'h14, rd, rsp);
    check("status asleep", rd, 32'h10);
    ev(5'h01);
    wait_resume(n, vec);
    check("vector inline", {31'h0, vec}, 32'h0);
    axi_write(8'h10, 32'h0, rsp);
    // Global enable set: wake from another source vectors
    axi_write(8'h00, 32'h80, rsp);
    sleep_pulse();
    other_irq_pending <= 8'h01;
    wait_resume(n, vec);
    other_irq_pending <= 8'h00;
    check("vector isr", {31'h0, vec}, 32'h1);
    $display("wake done");
    // Disabled source must not wake; watchdog time-out does
    axi_write(8'h00, 32'h00, rsp);
    sleep_pulse();
    ev(5'h10);
    repeat (8) @(posedge clock);
    check("asleep disabled", {31'h0, asleep}, 32'h1);
    @(posedge clock);
    watchdog_timeout_async <= 1'b1;
    @(posedge clock);
    watchdog_timeout_async <= 1'b0;
    wait_resume(n, vec);
    axi_read(8'h14, rd, rsp);
    check("status timeout", rd, 32'h00);
    clrwdt_exec <= 1'b1;
    @(posedge clock);
    clrwdt_exec <= 1'b0;
    axi_read(8'h14, rd, rsp);
    check("status after clear", rd, 32'h18);
    axi_write(8'h10, 32'h0, rsp);
    $display("timeout wake done");
    // Peripheral enable gates the interrupt request
    axi_write(8'h00, 32'hc0, rsp);
    ev(5'h01);
    repeat (4) @(posedge clock);
    check("irq with peripheral_irq_enable", {31'h0, irq_request}, 32'h1);
    axi_write(8'h00, 32'h80, rsp);
    repeat (2) @(posedge clock);
    check("irq without peripheral_irq_enable", {31'h0, irq_request}, 32'h0);
    axi_write(8'h10, 32'h0, rsp);
    axi_write(8'h00, 32'h00, rsp);
    // Crystal mode start-up delay
    axi_write(8'h1c, 32'h01, rsp);
    sleep_pulse();
    other_irq_pending <= 8'h01;
    wait_resume(n, vec);
    other_irq_pending <= 8'h00;
    check("startup delay", (n >= 1024) ? 32'h1 : 32'h0, 32'h1);
    $display("crystal start-up done");
    // Pin reset while asleep is a full reset, not a wake
    sleep_pulse();
    check("asleep before reset", {31'h0, asleep}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check("asleep after reset", {31'h0, asleep}, 32'h0);
    check("clock after reset", {31'h0, core_ctrl.cpu_clock_enable}, 32'h1);
    axi_read(8'h14, rd, rsp);
    check("status after reset", rd, 32'h18);
    $display("reset while asleep done");
    complete_run();
  end
endmodule // testbench
